// >>> gpi_func_pkg.sv
package gpi_func_pkg;
	localparam int PIN_COUNT = 4;
	localparam int ADDR_WIDTH = 8;
	// Register word indexes; byte address is four times the index
	localparam logic [7:0] INPUT_PIN_FUNC_CTRL_0_IDX = 8'h46;
	localparam logic [7:0] INPUT_PIN_FUNC_CTRL_1_IDX = 8'h47;
	localparam logic [7:0] INPUT_PIN_FUNC_CTRL_2_IDX = 8'h48;
	localparam logic [7:0] INPUT_PIN_FUNC_CTRL_3_IDX = 8'h49;
	localparam logic [7:0] PIN_LEVEL_STATUS_IDX = 8'h4a;
	localparam int FUNC_ENABLE_BIT = 0;
	localparam int FUNC_SEL_LSB = 1;
	localparam int FUNC_SEL_MSB = 4;
	localparam logic [7:0] FUNC_CTRL_RESET = 8'h00;
	localparam logic [3:0] SEL_HOLDOVER = 4'h1;
	localparam logic [3:0] SEL_REF_BIT1 = 4'h2;
	localparam logic [3:0] SEL_REF_BIT0 = 4'h3;
	localparam logic [3:0] SEL_SLEEP = 4'h4;
	localparam logic [3:0] SEL_MUTE = 4'h5;
	localparam logic [3:0] SEL_VCO_TYPE = 4'h6;
	localparam logic [3:0] SEL_HIGH_PERF = 4'h7;
	localparam logic [3:0] SEL_PULSE_GEN = 4'h8;
	localparam logic [3:0] SEL_RESEED = 4'h9;
	localparam logic [3:0] SEL_RESTART = 4'ha;
	localparam logic [3:0] SEL_FANOUT = 4'hb;
	localparam logic [3:0] SEL_SLIP = 4'hd;
	localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
endpackage

// >>> general_input_function_decoder.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [RULE_01] Four control registers each hold a 4-bit function selector in bits 4:1.
// [RULE_02] Code 0001: asserted pin forces the reference loop into holdover.
// [RULE_03] Codes 0010 and 0011 give bits 1 and 0 of manual reference selection.
// [RULE_04] Code 0100: pin puts the whole device to sleep.
// [RULE_05] Code 0101 issues output mute; code 1000 issues pulse generator request.
// [RULE_06] Code 0110: pin selects the oscillator core type manually.
// [RULE_07] Code 0111: pin selects high performance for synthesis loop and oscillator.
// [RULE_08] Code 1001: pin issues a reseed request to the output dividers.
// [RULE_09] Code 1010: pin issues a restart request.
// [RULE_10] Code 1011: pin forces fanout operation.
// [RULE_11] Code 1101: pin issues a slip request.
// [RULE_12] Bit 0 enables the selected function; clear means the pin has no effect.
// [RULE_13] Software disables the pin before changing its selector, then re-enables it.
// [RULE_14] A pin may serve an output function and an input function together.
// [RULE_15] Reserved codes 0000, 1100, 1110, 1111 drive no action even when enabled.
// [RULE_16] Pin levels pass a two-stage synchroniser before driving any action.
module general_input_function_decoder
	import gpi_func_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Avalon-MM slave
	input wire logic [ADDR_WIDTH+1:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWriteData,
	input wire logic [3:0] avsByteEnable,
	output logic [31:0] avsReadData,
	output logic avsWaitRequest,
	// Input pins
	input wire logic [PIN_COUNT-1:0] generalInputPin,
	// Internal actions
	output logic referenceLoopHoldover,
	output logic [1:0] manualRefSelect,
	output logic deviceSleep,
	output logic outputMute,
	output logic vcoTypeSelect,
	output logic highPerfMode,
	output logic pulseGenRequest,
	output logic reseedRequest,
	output logic restartRequest,
	output logic fanoutMode,
	output logic slipRequest
);

	typedef enum logic [2:0] {
		BUS_IDLE = 3'b001,
		BUS_ACK = 3'b010,
		BUS_DONE = 3'b100
	} bus_state_e;

	logic [7:0] funcCtrl [PIN_COUNT];
	logic [PIN_COUNT-1:0] pinMeta;
	logic [PIN_COUNT-1:0] pinSync;
	bus_state_e busState;
	logic [7:0] regIndex;
	logic idxHit;
	logic [1:0] idxPin;
	logic writeAccept;
	logic readTaken;
	logic next_holdover;
	logic [1:0] next_refSelect;
	logic next_sleep;
	logic next_mute;
	logic next_vcoType;
	logic next_highPerf;
	logic next_pulseGen;
	logic next_reseed;
	logic next_restart;
	logic next_fanout;
	logic next_slip;

	// OR of synced pin levels whose enabled selector equals code
	function automatic logic pinsDriving(
		input logic [3:0] code,
		input logic [PIN_COUNT-1:0] levels,
		input logic [7:0] c0,
		input logic [7:0] c1,
		input logic [7:0] c2,
		input logic [7:0] c3
	);
		logic [7:0] cfg [PIN_COUNT];
		logic hit;
		cfg[0] = c0;
		cfg[1] = c1;
		cfg[2] = c2;
		cfg[3] = c3;
		hit = 1'b0;
		for (int i = 0; i < PIN_COUNT; i++) begin
			if (cfg[i][FUNC_ENABLE_BIT] && cfg[i][FUNC_SEL_MSB:FUNC_SEL_LSB] == code && levels[i]) begin // RULE_12 RULE_15
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	assign regIndex = avsAddress[ADDR_WIDTH+1:2];
	assign idxHit = regIndex >= INPUT_PIN_FUNC_CTRL_0_IDX && regIndex <= INPUT_PIN_FUNC_CTRL_3_IDX;
	assign idxPin = 2'(regIndex - INPUT_PIN_FUNC_CTRL_0_IDX);
	assign writeAccept = busState == BUS_ACK && avsWrite && idxHit && avsByteEnable[0];
	assign readTaken = busState == BUS_IDLE && avsRead;

	// First synchroniser stage; sampled whatever the pin also drives
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pinMeta <= '0;
		end else begin
			pinMeta <= generalInputPin; // RULE_16 RULE_14
		end
	end

	// Second stage; the only reader of the first
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pinSync <= '0;
		end else begin
			pinSync <= pinMeta; // RULE_16
		end
	end

	// Bus handshake: one wait cycle, then ack, then one dead cycle
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			busState <= BUS_IDLE;
		end else begin
			case (busState)
				BUS_IDLE: begin
					if (avsRead || avsWrite) begin
						busState <= BUS_ACK;
					end
				end
				BUS_ACK: begin
					busState <= BUS_DONE;
				end
				BUS_DONE: begin
					busState <= BUS_IDLE;
				end
				default: begin
					busState <= BUS_IDLE;
				end
			endcase
		end
	end

	// Wait request low only in the cycle after a request is taken
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			avsWaitRequest <= 1'b1;
		end else begin
			avsWaitRequest <= !(busState == BUS_IDLE && (avsRead || avsWrite));
		end
	end

	// Control registers, written on the accepting edge
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < PIN_COUNT; i++) begin
				funcCtrl[i] <= FUNC_CTRL_RESET;
			end
		end else if (writeAccept) begin
			funcCtrl[idxPin] <= avsWriteData[7:0]; // RULE_01
		end
	end

	// Read data prepared when the request is first seen
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			avsReadData <= UNMAPPED_READ;
		end else if (readTaken) begin
			if (idxHit) begin
				avsReadData <= {24'h000000, 3'b000, funcCtrl[idxPin][4:0]};
			end else if (regIndex == PIN_LEVEL_STATUS_IDX) begin
				avsReadData <= {28'h0000000, pinSync};
			end else begin
				avsReadData <= UNMAPPED_READ;
			end
		end
	end

	// Reserved codes match no action below
	always_comb begin
		next_holdover = pinsDriving(SEL_HOLDOVER, pinSync, // RULE_02
			funcCtrl[0], funcCtrl[1], funcCtrl[2], funcCtrl[3]);
		next_refSelect[1] = pinsDriving(SEL_REF_BIT1, pinSync, // RULE_03
			funcCtrl[0], funcCtrl[1], funcCtrl[2], funcCtrl[3]);
		next_refSelect[0] = pinsDriving(SEL_REF_BIT0, pinSync, // RULE_03
			funcCtrl[0], funcCtrl[1], funcCtrl[2], funcCtrl[3]);
		next_sleep = pinsDriving(SEL_SLEEP, pinSync, // RULE_04
			funcCtrl[0], funcCtrl[1], funcCtrl[2], funcCtrl[3]);
		next_mute = pinsDriving(SEL_MUTE, pinSync, // RULE_05
			funcCtrl[0], funcCtrl[1], funcCtrl[2], funcCtrl[3]);
		next_pulseGen = pinsDriving(SEL_PULSE_GEN, pinSync, // RULE_05
			funcCtrl[0], funcCtrl[1], funcCtrl[2], funcCtrl[3]);
		next_vcoType = pinsDriving(SEL_VCO_TYPE, pinSync, // RULE_06
			funcCtrl[0], funcCtrl[1], funcCtrl[2], funcCtrl[3]);
		next_highPerf = pinsDriving(SEL_HIGH_PERF, pinSync, // RULE_07
			funcCtrl[0], funcCtrl[1], funcCtrl[2], funcCtrl[3]);
		next_reseed = pinsDriving(SEL_RESEED, pinSync, // RULE_08
			funcCtrl[0], funcCtrl[1], funcCtrl[2], funcCtrl[3]);
		next_restart = pinsDriving(SEL_RESTART, pinSync, // RULE_09
			funcCtrl[0], funcCtrl[1], funcCtrl[2], funcCtrl[3]);
		next_fanout = pinsDriving(SEL_FANOUT, pinSync, // RULE_10
			funcCtrl[0], funcCtrl[1], funcCtrl[2], funcCtrl[3]);
		next_slip = pinsDriving(SEL_SLIP, pinSync, // RULE_11
			funcCtrl[0], funcCtrl[1], funcCtrl[2], funcCtrl[3]);
	end

	// Holdover force to the reference loop
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			referenceLoopHoldover <= 1'b0;
		end else begin
			referenceLoopHoldover <= next_holdover; // RULE_02
		end
	end

	// Manual reference selection bits
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			manualRefSelect <= 2'b00;
		end else begin
			manualRefSelect <= next_refSelect; // RULE_03
		end
	end

	// Whole-device sleep
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			deviceSleep <= 1'b0;
		end else begin
			deviceSleep <= next_sleep; // RULE_04
		end
	end

	// Output mute
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			outputMute <= 1'b0;
		end else begin
			outputMute <= next_mute; // RULE_05
		end
	end

	// Oscillator core type
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			vcoTypeSelect <= 1'b0;
		end else begin
			vcoTypeSelect <= next_vcoType; // RULE_06
		end
	end

	// High performance mode
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			highPerfMode <= 1'b0;
		end else begin
			highPerfMode <= next_highPerf; // RULE_07
		end
	end

	// Pulse generator request, a level following the pin
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pulseGenRequest <= 1'b0;
		end else begin
			pulseGenRequest <= next_pulseGen; // RULE_05
		end
	end

	// Reseed request to the output dividers
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			reseedRequest <= 1'b0;
		end else begin
			reseedRequest <= next_reseed; // RULE_08
		end
	end

	// Restart request
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			restartRequest <= 1'b0;
		end else begin
			restartRequest <= next_restart; // RULE_09
		end
	end

	// Fanout operation
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			fanoutMode <= 1'b0;
		end else begin
			fanoutMode <= next_fanout; // RULE_10
		end
	end

	// Slip request
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			slipRequest <= 1'b0;
		end else begin
			slipRequest <= next_slip; // RULE_11
		end
	end

endmodule
`default_nettype wire

// >>> gpi_checker.sv
`timescale 1ns/1ps
`default_nettype none
module gpi_checker (
	// Clock and bus
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic avsWaitRequest,
	// Pins and actions
	input wire logic [3:0] generalInputPin,
	input wire logic referenceLoopHoldover,
	input wire logic [1:0] manualRefSelect,
	input wire logic deviceSleep,
	input wire logic outputMute,
	input wire logic vcoTypeSelect,
	input wire logic reseedRequest,
	input wire logic slipRequest
);
	logic [2:0] quietCnt;
	wire logic quiet = quietCnt > 3'h4;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Edges since any pin was high
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) quietCnt <= 3'h0;
		else if (|generalInputPin) quietCnt <= 3'h0;
		else if (quietCnt != 3'h7) quietCnt <= quietCnt + 3'h1;
	end
	wait_once_a: assert property (!avsWaitRequest |=> avsWaitRequest) else $error("wait low twice");
	hold_idle_a: assert property (quiet |-> !referenceLoopHoldover) else $error("holdover");
	ref_idle_a: assert property (quiet |-> manualRefSelect == 2'h0) else $error("ref select");
	sleep_idle_a: assert property (quiet |-> !deviceSleep) else $error("sleep");
	mute_idle_a: assert property (quiet[*2] |-> !outputMute) else $error("mute");
	vco_idle_a: assert property (quiet |=> !vcoTypeSelect) else $error("vco type");
	reseed_idle_a: assert property (quiet |-> !reseedRequest) else $error("reseed");
	slip_idle_a: assert property (quiet |-> !slipRequest) else $error("slip");
	cover property (!avsWaitRequest);
	cover property ($rose(deviceSleep));
	cover property ($rose(slipRequest));
endmodule
bind general_input_function_decoder gpi_checker chk_u (.mclk, .reset_n, .avsWaitRequest, .generalInputPin,
	.referenceLoopHoldover, .manualRefSelect, .deviceSleep, .outputMute, .vcoTypeSelect, .reseedRequest, .slipRequest);
`default_nettype wire

// >>> pin_driver.sv
`timescale 1ns/1ps
`default_nettype none
module pin_driver (
	// Clock
	input wire logic mclk,
	// Requested and driven levels
	input wire logic [3:0] want,
	output logic [3:0] pins
);
	// Levels move just after an edge, like a clocked controller
	always_ff @(posedge mclk) pins <= want;
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin nFail++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top;
	import gpi_func_pkg::*;
	logic mclk = 1'b0, reset_n = 1'b0, avsRead = 1'b0, avsWrite = 1'b0, avsWaitRequest;
	logic [9:0] avsAddress = 10'h0;
	logic [31:0] avsWriteData = 32'h0, avsReadData, q;
	logic referenceLoopHoldover, deviceSleep, outputMute, vcoTypeSelect, highPerfMode, pulseGenRequest;
	logic reseedRequest, restartRequest, fanoutMode, slipRequest;
	logic [1:0] manualRefSelect;
	logic [3:0] want = 4'h0, pins, p, avsByteEnable = 4'h1;
	logic [7:0] cfg [4];
	int nFail = 0, checked = 0, cyc = 0, k;
	wire logic [11:0] acts = {referenceLoopHoldover, manualRefSelect, deviceSleep, outputMute, vcoTypeSelect,
		highPerfMode, pulseGenRequest, reseedRequest, restartRequest, fanoutMode, slipRequest};
	pin_driver far_u (.mclk, .want, .pins);
	general_input_function_decoder dut_u (.mclk, .reset_n, .avsAddress, .avsRead, .avsWrite, .avsWriteData,
		.avsByteEnable, .avsReadData, .avsWaitRequest, .generalInputPin(pins), .referenceLoopHoldover,
		.manualRefSelect, .deviceSleep, .outputMute, .vcoTypeSelect, .highPerfMode, .pulseGenRequest,
		.reseedRequest, .restartRequest, .fanoutMode, .slipRequest);
	always #5 mclk = ~mclk;
	task automatic conclude();
		$display("checked=%0d nFail=%0d", checked, nFail);
		if (nFail == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 6000) begin
			nFail++;
			conclude();
		end
	end
	task automatic acc(input logic wr, input logic [7:0] idx, input logic [7:0] d);
		@(posedge mclk);
		avsAddress <= {idx, 2'b00};
		avsWrite <= wr;
		avsRead <= !wr;
		avsWriteData <= {24'h0, d};
		do @(posedge mclk); while (avsWaitRequest !== 1'b0);
		q = avsReadData;
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
	endtask
	// Disable, change selector, then enable again only if en is set
	task automatic setPin(input int i, input logic [3:0] code, input logic en);
		cfg[i][0] = 1'b0;
		acc(1'b1, INPUT_PIN_FUNC_CTRL_0_IDX + 8'(i), cfg[i]);
		cfg[i] = {3'h0, code, 1'b0};
		acc(1'b1, INPUT_PIN_FUNC_CTRL_0_IDX + 8'(i), cfg[i]);
		cfg[i][0] = en;
		if (en) acc(1'b1, INPUT_PIN_FUNC_CTRL_0_IDX + 8'(i), cfg[i]);
	endtask
	function automatic logic [11:0] model(input logic [3:0] lv);
		logic [11:0] r;
		r = 12'h0;
		for (int i = 0; i < 4; i++)
			if (cfg[i][0] && lv[i]) begin
				if (cfg[i][4:1] inside {[4'h1:4'hb]}) r[12 - cfg[i][4:1]] = 1'b1;
				else if (cfg[i][4:1] == SEL_SLIP) r[0] = 1'b1;
			end
		return r;
	endfunction
	initial begin
		void'($urandom(32'h581b));
		for (int i = 0; i < 4; i++) cfg[i] = 8'h00;
		repeat (3) @(posedge mclk);
		reset_n <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			acc(1'b0, INPUT_PIN_FUNC_CTRL_0_IDX + 8'(i), 8'h0);
			`CHK("ctrl reset", {24'h0, FUNC_CTRL_RESET}, q)
		end
		acc(1'b0, 8'h4b, 8'h0);
		`CHK("unmapped", UNMAPPED_READ, q)
		avsByteEnable <= 4'he;
		acc(1'b1, INPUT_PIN_FUNC_CTRL_1_IDX, 8'h1f);
		avsByteEnable <= 4'h1;
		acc(1'b0, INPUT_PIN_FUNC_CTRL_1_IDX, 8'h0);
		`CHK("lane gated", {24'h0, FUNC_CTRL_RESET}, q)
		for (int c = 0; c < 16; c++) begin
			want <= 4'h0;
			setPin(0, 4'(c), 1'b1);
			acc(1'b0, INPUT_PIN_FUNC_CTRL_0_IDX, 8'h0);
			`CHK("ctrl readback", {27'h0, 4'(c), 1'b1}, q)
			want <= 4'h1;
			repeat (2) @(posedge mclk);
			#1 `CHK("early", 12'h0, acts)
			repeat (4) @(posedge mclk);
			#1 `CHK("action", model(4'h1), acts)
			setPin(0, 4'(c), 1'b0);
			repeat (5) @(posedge mclk);
			#1 `CHK("disabled", 12'h0, acts)
		end
		for (int n = 0; n < 24; n++) begin
			k = $urandom % 4;
			setPin(k, 4'($urandom), 1'($urandom));
			p = 4'($urandom);
			want <= p;
			repeat (6) @(posedge mclk);
			#1 `CHK("random", model(p), acts)
			acc(1'b0, PIN_LEVEL_STATUS_IDX, 8'h0);
			`CHK("pin status", {28'h0, p}, q)
		end
		conclude();
	end
endmodule
`default_nettype wire
